// ---- cmtg_axil_slave.sv ----
// AXI4-Lite slave front end: turns bus handshakes into register strobes.
// Assumes the register file answers rd_data_in and decode flags in the
// same cycle as the strobes.
`timescale 1ns/1ps
`default_nettype none

module cmtg_axil_slave #(
	parameter int AW = 12
) (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic [AW-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [AW-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic wr_en_out,
	output logic [AW-1:0] wr_addr_out,
	output logic [31:0] wr_data_out,
	output logic [3:0] wr_strb_out,
	input wire logic wr_ok_in,
	output logic rd_en_out,
	output logic [AW-1:0] rd_addr_out,
	input wire logic [31:0] rd_data_in,
	input wire logic rd_ok_in
);
	logic aw_full_r;
	logic w_full_r;
	logic [AW-1:0] awaddr_r;
	logic [31:0] wdata_r;
	logic [3:0] wstrb_r;

	// ------------------------------------------------------------------
	// Write path: address and data held independently
	// ------------------------------------------------------------------
	assign s_axi_awready = !aw_full_r;
	assign s_axi_wready = !w_full_r;
	assign wr_en_out = aw_full_r && w_full_r && !s_axi_bvalid;
	assign wr_addr_out = awaddr_r;
	assign wr_data_out = wdata_r;
	assign wr_strb_out = wstrb_r;

	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			awaddr_r <= '0;
			wdata_r <= 32'h0000_0000;
			wstrb_r <= 4'h0;
		end else begin
			if (s_axi_awvalid && !aw_full_r) begin
				aw_full_r <= 1'b1;
				awaddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && !w_full_r) begin
				w_full_r <= 1'b1;
				wdata_r <= s_axi_wdata;
				wstrb_r <= s_axi_wstrb;
			end
			// Buffers free only once the write has been done
			if (wr_en_out) begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
			end
		end
	end

	// Write response, SLVERR for an unmapped address
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else if (wr_en_out) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wr_ok_in ? 2'h0 : 2'h2;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Read path: one read in flight, data registered
	// ------------------------------------------------------------------
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_en_out = s_axi_arvalid && !s_axi_rvalid;
	assign rd_addr_out = s_axi_araddr;

	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= 2'h0;
		end else if (rd_en_out) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata <= rd_ok_in ? rd_data_in : 32'h0000_0000;
			s_axi_rresp <= rd_ok_in ? 2'h0 : 2'h2;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule
`default_nettype wire

// ---- cmtg_consts.svh ----
// Constants of the clock mode and tick generator: offsets, fields,
// reset values and tick placement fractions.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef CMTG_CONSTS_SVH
`define CMTG_CONSTS_SVH

// ------------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------------
`define CMTG_CTRL_OFF 12'h000
`define CMTG_STATUS_OFF 12'h004
`define CMTG_PHASE_OFF 12'h008

// ------------------------------------------------------------------
// Field positions and reset values
// ------------------------------------------------------------------
`define CMTG_CTRL_RATIO_LSB 0
`define CMTG_CTRL_UPM_TICK_LSB 4
`define CMTG_CTRL_RESET 32'h0000_0000
`define CMTG_STAT_MODE_LSB 0
`define CMTG_STAT_RANGE_BIT 2
`define CMTG_STAT_CFG_LSB 3
`define CMTG_STAT_VALID_BIT 16
`define CMTG_CFG_WORD_CLK_LSB 28

// ------------------------------------------------------------------
// Tick timing: fast clocks per bus input clock cycle, tick fractions
// ------------------------------------------------------------------
`define CMTG_PERIOD_DEF 140
`define CMTG_PERIOD_QUANTUM 140
`define CMTG_T3_NUM 1
`define CMTG_T3_DEN 2
`define CMTG_INT_T2_NUM 1
`define CMTG_INT_T4_NUM 3
`define CMTG_INT_DEN 4
`define CMTG_R25_T2_NUM 3
`define CMTG_R25_T4_NUM 8
`define CMTG_R25_DEN 10
`define CMTG_R35_T2_NUM 4
`define CMTG_R35_T4_NUM 11
`define CMTG_R35_DEN 14

`endif

// ---- cmtg_pkg.sv ----
// Types shared by the clock mode and tick generator modules.
// Assumes cmtg_consts.svh is on the include path.
`include "cmtg_consts.svh"

package cmtg_pkg;

	// Clocking mode chosen by the straps
	typedef enum logic [1:0] {
		CMTG_MODE_LOCAL,
		CMTG_MODE_HOST,
		CMTG_MODE_AGENT
	} cmtg_mode_type;

	// Bridge clock range in host or agent mode
	typedef enum logic {
		CMTG_RANGE_50_66,
		CMTG_RANGE_25_50
	} cmtg_range_type;

	// Core PLL ratio class, sets where ticks two and four land
	typedef enum logic [1:0] {
		CMTG_RATIO_WHOLE,
		CMTG_RATIO_2P5,
		CMTG_RATIO_3P5
	} cmtg_ratio_type;

endpackage

// ---- cmtg_strap_src.sv ----
// Partner model: board straps and the reset configuration word.
// Assumes the bench sets code, ratio pins and high bits before reset.
`timescale 1ns/1ps
`default_nettype none

module cmtg_strap_src (
	input wire logic [2:0] code_in,
	input wire logic [2:0] pins_in,
	input wire logic [3:0] hi_in,
	output logic sel_out,
	output logic agent_out,
	output logic [2:0] pins_out,
	output logic [31:0] word_out,
	output logic [5:0] lines_out
);
	// ------------------------------------------------------------
	// Strap drive, code is {local, agent, range}
	// ------------------------------------------------------------
	assign sel_out = code_in[2];
	assign agent_out = code_in[1];
	assign pins_out = pins_in;
	// Unused source carries inverted bits so a wrong pick shows
	assign word_out = code_in[2] ? {hi_in, 28'h5a5a5a5} :
		{~hi_in, 28'ha5a5a5a};
	assign lines_out = code_in[2] ? {2'b11, ~hi_in} :
		{code_in[0], 1'b0, hi_in[0], hi_in[1], hi_in[2], hi_in[3]};
endmodule
`default_nettype wire

// ---- cmtg_tick_gen.sv ----
// Tick generator: splits each bus input clock cycle into four ticks.
// Assumes the fast clock runs PERIOD times the bus input clock rate.
`timescale 1ns/1ps
`default_nettype none
`include "cmtg_consts.svh"

module cmtg_tick_gen #(
	parameter int PERIOD = `CMTG_PERIOD_DEF
) (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire cmtg_pkg::cmtg_ratio_type ratio_in,
	output logic [7:0] phase_out,
	output logic bus_clk_out,
	output logic tick_one_out,
	output logic tick_two_out,
	output logic tick_three_out,
	output logic tick_four_out
);
	import cmtg_pkg::*;

	// Exact placement needs a period divisible by 4, 10 and 14
	if (PERIOD % `CMTG_PERIOD_QUANTUM != 0 || PERIOD > 255) begin : g_chk
		$error("cmtg_tick_gen: PERIOD must be a multiple of 140, max 140");
	end

	// Position of a tick as a phase count
	function automatic logic [7:0] tick_pos(input int num, input int den);
		int p;
		p = (PERIOD * num) / den;
		return p[7:0];
	endfunction

	logic [7:0] phase_r;
	logic [7:0] t2_pos;
	logic [7:0] t4_pos;
	cmtg_ratio_type ratio_r;

	// ------------------------------------------------------------------
	// Phase counter
	// ------------------------------------------------------------------
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			phase_r <= 8'h00;
		end else if (phase_r == 8'(PERIOD - 1)) begin
			phase_r <= 8'h00;
		end else begin
			phase_r <= phase_r + 8'h01;
		end
	end

	// Ratio taken only at a cycle boundary, so a class change in
	// mid-cycle never splits a tick two and tick four pair
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			ratio_r <= CMTG_RATIO_WHOLE;
		end else if (phase_r == 8'(PERIOD - 1)) begin
			ratio_r <= ratio_in;
		end
	end

	// ------------------------------------------------------------------
	// Tick placement by ratio class
	// ------------------------------------------------------------------
	always_comb begin
		case (ratio_r)
			CMTG_RATIO_2P5: begin
				t2_pos = tick_pos(`CMTG_R25_T2_NUM, `CMTG_R25_DEN);
				t4_pos = tick_pos(`CMTG_R25_T4_NUM, `CMTG_R25_DEN);
			end
			CMTG_RATIO_3P5: begin
				t2_pos = tick_pos(`CMTG_R35_T2_NUM, `CMTG_R35_DEN);
				t4_pos = tick_pos(`CMTG_R35_T4_NUM, `CMTG_R35_DEN);
			end
			default: begin
				t2_pos = tick_pos(`CMTG_INT_T2_NUM, `CMTG_INT_DEN);
				t4_pos = tick_pos(`CMTG_INT_T4_NUM, `CMTG_INT_DEN);
			end
		endcase
	end

	// Ticks are one-cycle pulses; the bus clock is high in the first half
	assign phase_out = phase_r;
	assign tick_one_out = (phase_r == 8'h00);
	assign tick_two_out = (phase_r == t2_pos);
	assign tick_three_out = (phase_r == tick_pos(`CMTG_T3_NUM, `CMTG_T3_DEN));
	assign tick_four_out = (phase_r == t4_pos);
	assign bus_clk_out = (phase_r < tick_pos(`CMTG_T3_NUM, `CMTG_T3_DEN));

endmodule
`default_nettype wire

// ---- cmtg_top.sv ----
// Clock mode selection and memory controller tick timing.
// Assumes straps are stable around reset release and all inputs are
// synchronous to mclk_in; reset_n_in acts as the power-on reset.
`timescale 1ns/1ps
`default_nettype none
`include "cmtg_consts.svh"

module cmtg_top #(
	parameter int PERIOD = `CMTG_PERIOD_DEF,
	parameter int UPM_W = 6,
	parameter int CTL_W = 8,
	parameter int BUS_W = 8
) (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic bridge_select_strap_in,
	input wire logic host_agent_strap_in,
	input wire logic [2:0] clock_ratio_strap_pins_in,
	input wire logic [31:0] config_word_in,
	input wire logic [5:0] local_general_lines_in,
	input wire logic [UPM_W-1:0] upm_data_in,
	input wire logic [CTL_W-1:0] ctl_data_in,
	input wire logic [BUS_W-1:0] bus_data_in,
	output logic [UPM_W-1:0] upm_data_out,
	output logic [CTL_W-1:0] ctl_data_out,
	output logic [BUS_W-1:0] bus_data_out,
	output logic bus_input_clock_out,
	output logic tick_phase_one_out,
	output logic tick_phase_two_out,
	output logic tick_phase_three_out,
	output logic tick_phase_four_out,
	output cmtg_pkg::cmtg_mode_type mode_out,
	output cmtg_pkg::cmtg_range_type bridge_freq_range_out,
	output logic [6:0] clock_config_out,
	output logic config_valid_out
);
	import cmtg_pkg::*;

	if (UPM_W < 1 || UPM_W > 32 || CTL_W < 1 || BUS_W < 1) begin : g_chk
		$error("cmtg_top: data widths must be 1 or more, UPM_W at most 32");
	end

	logic captured_r;
	cmtg_mode_type mode_r;
	cmtg_range_type range_r;
	logic [6:0] cfg_r;
	cmtg_ratio_type ratio_r;
	logic [1:0] upm_tick_r;
	logic [UPM_W-1:0] upm_r;
	logic [CTL_W-1:0] ctl_r;
	logic [BUS_W-1:0] bus_r;
	logic [7:0] phase;
	logic t1, t2, t3, t4;
	logic upm_tick;
	logic wr_en, wr_ok, rd_ok;
	logic [11:0] wr_addr, rd_addr;
	logic [31:0] wr_data, rd_data;
	logic [3:0] wr_strb;
	cmtg_mode_type mode_nxt;
	logic [3:0] cfg_hi_nxt;

	// ------------------------------------------------------------------
	// Strap decode
	// ------------------------------------------------------------------
	// Mode from the two mode straps; the select strap outranks the host/agent strap
	always_comb begin
		if (bridge_select_strap_in) begin
			mode_nxt = CMTG_MODE_LOCAL;
		end else if (!host_agent_strap_in) begin
			mode_nxt = CMTG_MODE_HOST;
		end else begin
			mode_nxt = CMTG_MODE_AGENT;
		end
	end

	// Upper config bits: word bits in local mode, lines 0..3 otherwise
	always_comb begin
		if (mode_nxt == CMTG_MODE_LOCAL) begin
			cfg_hi_nxt = config_word_in[`CMTG_CFG_WORD_CLK_LSB +: 4];
		end else begin
			cfg_hi_nxt = {local_general_lines_in[0], local_general_lines_in[1],
				local_general_lines_in[2], local_general_lines_in[3]};
		end
	end

	// ------------------------------------------------------------------
	// Configuration capture
	// ------------------------------------------------------------------
	// Taken once, the first clock after reset release; later strap
	// changes are ignored until the next power-on reset
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			captured_r <= 1'b0;
			mode_r <= CMTG_MODE_LOCAL;
			range_r <= CMTG_RANGE_50_66;
			cfg_r <= 7'h00;
		end else if (!captured_r) begin
			captured_r <= 1'b1;
			mode_r <= mode_nxt;
			cfg_r <= {cfg_hi_nxt, clock_ratio_strap_pins_in};
			// Range strap only matters off the local bus
			if (mode_nxt != CMTG_MODE_LOCAL && local_general_lines_in[5]) begin
				range_r <= CMTG_RANGE_25_50;
			end else begin
				range_r <= CMTG_RANGE_50_66;
			end
		end
	end

	assign mode_out = mode_r;
	assign bridge_freq_range_out = range_r;
	assign clock_config_out = cfg_r;
	assign config_valid_out = captured_r;

	// ------------------------------------------------------------------
	// Control register
	// ------------------------------------------------------------------
	// Ratio class 3 is not a valid class and is stored as whole ratio
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			ratio_r <= cmtg_ratio_type'(`CMTG_CTRL_RESET);
			upm_tick_r <= 2'(`CMTG_CTRL_RESET);
		end else if (wr_en && wr_addr == `CMTG_CTRL_OFF && wr_strb[0]) begin
			case (wr_data[`CMTG_CTRL_RATIO_LSB +: 2])
				2'h1: ratio_r <= CMTG_RATIO_2P5;
				2'h2: ratio_r <= CMTG_RATIO_3P5;
				default: ratio_r <= CMTG_RATIO_WHOLE;
			endcase
			upm_tick_r <= wr_data[`CMTG_CTRL_UPM_TICK_LSB +: 2];
		end
	end

	// Write decode: status and phase are read-only, writes ignored
	assign wr_ok = (wr_addr == `CMTG_CTRL_OFF) ||
		(wr_addr == `CMTG_STATUS_OFF) || (wr_addr == `CMTG_PHASE_OFF);

	// Read decode; unmapped addresses answer SLVERR
	always_comb begin
		rd_data = 32'h0000_0000;
		rd_ok = 1'b1;
		case (rd_addr)
			`CMTG_CTRL_OFF: begin
				rd_data[`CMTG_CTRL_RATIO_LSB +: 2] = ratio_r;
				rd_data[`CMTG_CTRL_UPM_TICK_LSB +: 2] = upm_tick_r;
			end
			`CMTG_STATUS_OFF: begin
				rd_data[`CMTG_STAT_MODE_LSB +: 2] = mode_r;
				rd_data[`CMTG_STAT_RANGE_BIT] = range_r;
				rd_data[`CMTG_STAT_CFG_LSB +: 7] = cfg_r;
				rd_data[`CMTG_STAT_VALID_BIT] = captured_r;
			end
			`CMTG_PHASE_OFF: rd_data[7:0] = phase;
			default: rd_ok = 1'b0;
		endcase
	end

	// ------------------------------------------------------------------
	// Tick timing and timed outputs
	// ------------------------------------------------------------------
	cmtg_tick_gen #(
		.PERIOD(PERIOD)
	) u_ticks (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.ratio_in(ratio_r),
		.phase_out(phase),
		.bus_clk_out(bus_input_clock_out),
		.tick_one_out(t1),
		.tick_two_out(t2),
		.tick_three_out(t3),
		.tick_four_out(t4)
	);

	assign tick_phase_one_out = t1;
	assign tick_phase_two_out = t2;
	assign tick_phase_three_out = t3;
	assign tick_phase_four_out = t4;

	// Tick chosen by programming for the programmable machine
	always_comb begin
		case (upm_tick_r)
			2'h1: upm_tick = t2;
			2'h2: upm_tick = t3;
			2'h3: upm_tick = t4;
			default: upm_tick = t1;
		endcase
	end

	// Programmable machine outputs move on the selected tick only
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			upm_r <= '0;
		end else if (upm_tick) begin
			upm_r <= upm_data_in;
		end
	end

	// SDRAM and chip-select outputs ignore intermediate ticks
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			ctl_r <= '0;
		end else if (t1) begin
			ctl_r <= ctl_data_in;
		end
	end

	// Other bus and system outputs launch at the rising edge
	always_ff @(posedge mclk_in) begin
		if (!reset_n_in) begin
			bus_r <= '0;
		end else if (t1) begin
			bus_r <= bus_data_in;
		end
	end

	assign upm_data_out = upm_r;
	assign ctl_data_out = ctl_r;
	assign bus_data_out = bus_r;

	// ------------------------------------------------------------------
	// Register bus
	// ------------------------------------------------------------------
	cmtg_axil_slave #(
		.AW(12)
	) u_axil (
		.mclk_in(mclk_in),
		.reset_n_in(reset_n_in),
		.s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready),
		.s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid),
		.s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp),
		.s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready),
		.wr_en_out(wr_en),
		.wr_addr_out(wr_addr),
		.wr_data_out(wr_data),
		.wr_strb_out(wr_strb),
		.wr_ok_in(wr_ok),
		.rd_en_out(),
		.rd_addr_out(rd_addr),
		.rd_data_in(rd_data),
		.rd_ok_in(rd_ok)
	);

endmodule
`default_nettype wire

// ---- cmtg_top_monitor.sv ----
// Port checker for the clock mode and tick generator top.
// Assumes it is bound onto cmtg_top with the same data widths.
`timescale 1ns/1ps
`default_nettype none

module cmtg_top_monitor
	import cmtg_pkg::*;
#(
	parameter int UPM_W = 6,
	parameter int CTL_W = 8,
	parameter int BUS_W = 8
) (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic bridge_select_strap_in,
	input wire logic host_agent_strap_in,
	input wire logic [2:0] clock_ratio_strap_pins_in,
	input wire logic [31:0] config_word_in,
	input wire logic [5:0] local_general_lines_in,
	input wire logic [UPM_W-1:0] upm_data_in,
	input wire logic [CTL_W-1:0] ctl_data_in,
	input wire logic [UPM_W-1:0] upm_data_out,
	input wire logic [BUS_W-1:0] bus_data_out,
	input wire logic [CTL_W-1:0] ctl_data_out,
	input wire logic bus_input_clock_out,
	input wire logic tick_phase_one_out,
	input wire logic tick_phase_two_out,
	input wire logic tick_phase_three_out,
	input wire logic tick_phase_four_out,
	input wire cmtg_mode_type mode_out,
	input wire cmtg_range_type bridge_freq_range_out,
	input wire logic [6:0] clock_config_out,
	input wire logic config_valid_out
);
	logic sel_r, agent_r, any_tick, rst_ok_r;
	logic [2:0] pins_r;
	logic [3:0] hi_r;
	logic [5:0] lines_r;
	logic [1:0] exp_mode;
	logic [6:0] exp_cfg;

	// Straps as they stood at the capture edge
	always_ff @(posedge mclk_in) begin
		sel_r <= bridge_select_strap_in;
		agent_r <= host_agent_strap_in;
		pins_r <= clock_ratio_strap_pins_in;
		hi_r <= config_word_in[31:28];
		lines_r <= local_general_lines_in;
		rst_ok_r <= reset_n_in;
	end
	// Expected decode, built apart from the design's own logic
	assign exp_mode = sel_r ? 2'h0 : (agent_r ? 2'h2 : 2'h1);
	assign exp_cfg = {sel_r ? hi_r :
		{lines_r[0], lines_r[1], lines_r[2], lines_r[3]}, pins_r};
	assign any_tick = tick_phase_one_out | tick_phase_two_out |
		tick_phase_three_out | tick_phase_four_out;

	default clocking cb @(posedge mclk_in); endclocking
	// The release edge still sees the reset-time outputs, so checks
	// start one edge after the design has left reset
	default disable iff (!reset_n_in || !rst_ok_r);

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	mode_decode_a: assert property (
		$rose(config_valid_out) |-> mode_out == exp_mode)
		else $error("mode decode wrong");
	range_decode_a: assert property (
		$rose(config_valid_out) |->
		bridge_freq_range_out == (!sel_r && lines_r[5]))
		else $error("range decode wrong");
	config_bits_a: assert property (
		$rose(config_valid_out) |-> clock_config_out == exp_cfg)
		else $error("config bits wrong");
	config_hold_a: assert property (
		config_valid_out |=> $stable(mode_out) &&
		$stable(clock_config_out) && $stable(bridge_freq_range_out))
		else $error("config moved after capture");
	tick_period_a: assert property (
		tick_phase_one_out |-> ##140 tick_phase_one_out)
		else $error("tick one period wrong");
	half_cycle_a: assert property (
		tick_phase_one_out |-> bus_input_clock_out ##70
		(tick_phase_three_out && $fell(bus_input_clock_out)))
		else $error("tick three not at falling edge");
	tick_spread_a: assert property (
		tick_phase_two_out |-> ##70 tick_phase_four_out)
		else $error("tick two to four spacing wrong");
	upm_on_tick_a: assert property (
		!$stable(upm_data_out) |-> $past(any_tick))
		else $error("upm output moved off tick");
	ctl_load_a: assert property (
		tick_phase_one_out |=> ctl_data_out == $past(ctl_data_in))
		else $error("chip select output not loaded");
	bus_edge_a: assert property (
		!$stable(bus_data_out) |-> $past(tick_phase_one_out))
		else $error("bus output moved off rising edge");

	cover property (config_valid_out && mode_out == CMTG_MODE_LOCAL);
	cover property (config_valid_out && mode_out == CMTG_MODE_HOST);
	cover property (config_valid_out && mode_out == CMTG_MODE_AGENT);
endmodule

bind cmtg_top cmtg_top_monitor #(.UPM_W(UPM_W), .CTL_W(CTL_W),
	.BUS_W(BUS_W)) mon (.mclk_in(mclk_in), .reset_n_in(reset_n_in),
	.bridge_select_strap_in(bridge_select_strap_in),
	.host_agent_strap_in(host_agent_strap_in),
	.clock_ratio_strap_pins_in(clock_ratio_strap_pins_in),
	.config_word_in(config_word_in),
	.local_general_lines_in(local_general_lines_in),
	.upm_data_in(upm_data_in), .ctl_data_in(ctl_data_in),
	.upm_data_out(upm_data_out), .bus_data_out(bus_data_out),
	.ctl_data_out(ctl_data_out), .bus_input_clock_out(bus_input_clock_out),
	.tick_phase_one_out(tick_phase_one_out),
	.tick_phase_two_out(tick_phase_two_out),
	.tick_phase_three_out(tick_phase_three_out),
	.tick_phase_four_out(tick_phase_four_out), .mode_out(mode_out),
	.bridge_freq_range_out(bridge_freq_range_out),
	.clock_config_out(clock_config_out),
	.config_valid_out(config_valid_out));
`default_nettype wire

// ---- tb.sv ----
// Self-checking bench for the clock mode and tick generator.
// Assumes the strap source model and the bound port checker.
`timescale 1ns/1ps
`default_nettype none
`include "cmtg_consts.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fails++; \
	$display("[ERR] %0t got %h exp %h", $time, g, e); end end

module tb;
	import cmtg_pkg::*;
	localparam int PER = `CMTG_PERIOD_DEF;
	logic mclk_in = 0, reset_n_in = 0, awv = 0, wv = 0, bready = 0;
	logic arv = 0, rready = 0, awready, wready, bvalid, arready, rvalid;
	logic [11:0] awaddr = 0, araddr = 0;
	logic [31:0] wdata = 0, rdata, word;
	logic [3:0] wstrb = 0, hi = 0;
	wire logic [3:0] t;
	logic [1:0] bresp, rresp, em;
	logic [2:0] code = 3'h4, rpins = 0, pins;
	logic [5:0] upi = 0, upo, eu, lines;
	logic [7:0] cti = 0, bui = 0, cto, buo, ec, eb;
	logic [6:0] cfg;
	logic sel, agent, bclk, valid, er;
	cmtg_mode_type mode;
	cmtg_range_type rng;
	logic [2:0] codes [5] = '{3'h4, 3'h0, 3'h1, 3'h2, 3'h3};
	int fails = 0, compares = 0, cyc = 0;

	cmtg_strap_src straps (.code_in(code), .pins_in(rpins), .hi_in(hi),
		.sel_out(sel), .agent_out(agent), .pins_out(pins),
		.word_out(word), .lines_out(lines));
	cmtg_top #(.PERIOD(PER)) dut (.mclk_in(mclk_in),
		.reset_n_in(reset_n_in), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wv), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arv),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.bridge_select_strap_in(sel), .host_agent_strap_in(agent),
		.clock_ratio_strap_pins_in(pins), .config_word_in(word),
		.local_general_lines_in(lines), .upm_data_in(upi),
		.ctl_data_in(cti), .bus_data_in(bui), .upm_data_out(upo),
		.ctl_data_out(cto), .bus_data_out(buo), .bus_input_clock_out(bclk),
		.tick_phase_one_out(t[0]), .tick_phase_two_out(t[1]),
		.tick_phase_three_out(t[2]), .tick_phase_four_out(t[3]),
		.mode_out(mode), .bridge_freq_range_out(rng),
		.clock_config_out(cfg), .config_valid_out(valid));

	// ------------------------------------------------------------
	// Clock, hang guard and verdict
	// ------------------------------------------------------------
	always #5 mclk_in = ~mclk_in;
	// Cut a hang short well past the expected run length
	always @(posedge mclk_in) begin
		cyc++;
		if (cyc > 6000) begin
			fails++;
			end_of_test();
		end
	end
	task automatic end_of_test();
		$display("compares %0d fails %0d", compares, fails);
		if (fails == 0 && compares > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	// ------------------------------------------------------------
	// Bus master tasks, each holds its channel until taken
	// ------------------------------------------------------------
	task automatic axw(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [1:0] r);
		@(posedge mclk_in);
		awaddr <= a; wdata <= d; wstrb <= s; awv <= 1; wv <= 1; bready <= 1;
		do begin
			@(posedge mclk_in);
			if (awv && awready) awv <= 0;
			if (wv && wready) wv <= 0;
		end while (!bvalid);
		r = bresp;
		bready <= 0;
	endtask
	task automatic axr(input logic [11:0] a, output logic [31:0] d,
		output logic [1:0] r);
		@(posedge mclk_in);
		araddr <= a; arv <= 1; rready <= 1;
		do begin
			@(posedge mclk_in);
			if (arv && arready) arv <= 0;
		end while (!rvalid);
		d = rdata; r = rresp; rready <= 0;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		logic [31:0] d;
		logic [1:0] r;
		int k, i, p1, p2, p3, p4, e2, e4;
		void'($urandom(32'h3b466d37));
		// Every strap mode, then straps moved while running
		foreach (codes[n]) begin
			@(posedge mclk_in);
			code <= codes[n]; rpins <= 3'($urandom); hi <= 4'($urandom);
			reset_n_in <= 0;
			repeat (20) @(posedge mclk_in);
			reset_n_in <= 1;
			repeat (3) @(posedge mclk_in);
			em = codes[n][2] ? 2'h0 : (codes[n][1] ? 2'h2 : 2'h1);
			er = !codes[n][2] && codes[n][0];
			`CHK(mode, em)
			`CHK(rng, er)
			`CHK(cfg, {hi, rpins})
			axr(`CMTG_STATUS_OFF, d, r);
			`CHK(d, {15'h0, 1'b1, 6'h0, hi, rpins, er, em})
			code <= ~codes[n]; hi <= ~hi; rpins <= ~rpins;
			axw(`CMTG_STATUS_OFF, 32'hffffffff, 4'hf, r);
			`CHK(r, 2'h0)
			`CHK({mode, rng, cfg}, {em, er, ~hi, ~rpins})
		end
		// Reserved places and a write with no byte lanes
		axr(12'h00c, d, r);
		`CHK({r, d}, {2'h2, 32'h0})
		axw(12'h010, 32'h33, 4'hf, r);
		`CHK(r, 2'h2)
		axw(`CMTG_CTRL_OFF, 32'h31, 4'h0, r);
		axr(`CMTG_CTRL_OFF, d, r);
		`CHK(d, `CMTG_CTRL_RESET)
		axr(`CMTG_PHASE_OFF, d, r);
		`CHK(d < PER, 1'b1)
		// Each ratio class with a matching upm tick select
		for (k = 0; k < 4; k++) begin
			axw(`CMTG_CTRL_OFF, 32'((k << 4) | k), 4'hf, r);
			axr(`CMTG_CTRL_OFF, d, r);
			`CHK(d, 32'((k << 4) | (k == 3 ? 0 : k)))
			// Ticks are looked at once settled, so phase 0 is i = 0
			do begin
				@(posedge mclk_in);
				#1;
			end while (!t[0]);
			eu = upi; ec = cti; eb = bui; p1 = 0; p2 = 0; p3 = 0; p4 = 0;
			for (i = 0; i <= PER; i++) begin
				if (t[0]) p1 = i;
				if (t[1]) p2 = i;
				if (t[2]) p3 = i;
				if (t[3]) p4 = i;
				if (t[k]) eu = upi;
				if (t[0]) begin
					ec = cti;
					eb = bui;
				end
				@(posedge mclk_in);
				upi <= 6'($urandom); cti <= 8'($urandom); bui <= 8'($urandom);
				#1;
				`CHK(upo, eu)
				`CHK(cto, ec)
				`CHK(buo, eb)
			end
			e2 = PER * `CMTG_INT_T2_NUM / `CMTG_INT_DEN;
			e4 = PER * `CMTG_INT_T4_NUM / `CMTG_INT_DEN;
			if (k == 1) begin
				e2 = PER * `CMTG_R25_T2_NUM / `CMTG_R25_DEN;
				e4 = PER * `CMTG_R25_T4_NUM / `CMTG_R25_DEN;
			end
			if (k == 2) begin
				e2 = PER * `CMTG_R35_T2_NUM / `CMTG_R35_DEN;
				e4 = PER * `CMTG_R35_T4_NUM / `CMTG_R35_DEN;
			end
			`CHK(p1, PER)
			`CHK(p3, PER * `CMTG_T3_NUM / `CMTG_T3_DEN)
			`CHK(p2, e2)
			`CHK(p4, e4)
		end
		end_of_test();
	end
endmodule
`default_nettype wire
